// ==== include/lcpwm_pkg.sv ====
// Shared constants, register map and carrier types of the LED channel dimming block.
package lcpwm_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CH       = 16;          // Output channels, two per group.
  localparam int unsigned NUM_GROUPS   = 8;           // Phase groups A to H.
  localparam int unsigned PWM_STEPS    = 4096;        // Base ticks per dimming period.
  localparam int unsigned CLK_HZ       = 250_000_000; // Rate of ref_clk.
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam logic [11:0] PHASE_STEP   = 12'h200;     // One eighth of a period.
  localparam int unsigned SETTLE_W     = 24;          // Width of the settle counters.

  // Dimming frequency in Hz per select code.
  localparam int unsigned DIM_FREQ_HZ [16] = '{200, 300, 400, 500, 600, 800, 1000, 1200,
                                              1500, 2000, 3000, 4000, 6000, 8000, 12000,
                                              20800};
  // Settle delays in microseconds for each select code.
  localparam int unsigned SETTLE_US [16] = '{100, 20, 30, 50, 80, 150, 200, 300,
                                            500, 800, 1000, 1200, 1500, 2000, 3000, 4000};

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00; // Global configuration.
  localparam logic [7:0] ADDR_ENABLE   = 8'h04; // Channel enables.
  localparam logic [7:0] ADDR_STATUS   = 8'h08; // Live outputs and settle state.
  localparam logic [7:0] ADDR_FALLBACK = 8'h0c; // Write 1 to bit 0 to enter fallback.
  localparam logic [1:0] REGION_GLOBAL = 2'h0;  // paddr[7:6] for the words above.
  localparam logic [1:0] REGION_CODE   = 2'h1;  // 0x40 + 4*ch: current code.
  localparam logic [1:0] REGION_HIGH   = 2'h2;  // 0x80 + 4*ch: duty high byte.
  localparam logic [1:0] REGION_LOW    = 2'h3;  // 0xc0 + 4*ch: duty low nibble.

  // Field positions inside the configuration word.
  localparam int unsigned CTRL_GAIN_LSB   = 0;  // [1:0] full range gain select.
  localparam int unsigned CTRL_FREQ_LSB   = 2;  // [5:2] dimming frequency select.
  localparam int unsigned CTRL_SETTLE_LSB = 6;  // [9:6] settle delay select.
  localparam int unsigned CTRL_STAGGER    = 10; // Phase stagger enable.
  localparam int unsigned CTRL_CURVE      = 11; // Exponential curve select.
  localparam int unsigned CTRL_COMMON     = 12; // Common duty enable.
  localparam int unsigned CTRL_FULLRES    = 13; // Full 12-bit resolution select.

  // Values after reset.
  localparam logic [1:0] GAIN_RESET    = 2'h3;
  localparam logic [3:0] SETTLE_RESET  = 4'h0;
  localparam logic       FULLRES_RESET = 1'b1;
  localparam logic [5:0] CODE_RESET    = 6'h00;
  localparam logic [7:0] HIGH_RESET    = 8'h00;
  localparam logic [3:0] LOW_RESET     = 4'h0;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  // Stored nonvolatile defaults.
  typedef struct packed {
    logic                    curve_select;
    logic [3:0]              dimming_freq_select;
    logic [NUM_CH-1:0][7:0]  duty_high_byte;
    logic [NUM_CH-1:0][3:0]  duty_low_nibble;
  } lcpwm_nv_t;

  // Drive toward the current sources.
  typedef struct packed {
    logic [1:0]              ref_gain_select;
    logic [9:0]              gain_multiplier;
    logic [NUM_CH-1:0][5:0]  channel_current_code;
    logic [NUM_CH-1:0]       current_output_channel;
    logic [NUM_CH-1:0]       sample_ok;
  } lcpwm_drive_t;

  // Applied duty: code plus forced full-on.
  typedef struct packed {
    logic        full_on;
    logic [11:0] code;
  } lcpwm_duty_t;

endpackage

// ==== core/lcpwm_top.sv ====
// Sixteen-channel LED current and PWM dimming logic, APB slave.
//
// How it works
// - gain code selects multiplier
// - enable bit gates channel current
// - enables clear at reset
// - six-bit current code per channel
// - 4096-tick period, on for duty ticks
// - base tick is 4096 times frequency
// - settle timer gates sampling after turn-on
// - settle codes map to delay table
// - one microsecond pulses supported above 200 Hz
// - no stagger: all switch together
// - stagger pairs A to H, phases 0-7
// - each group lags an eighth period
// - linear mode joins byte and nibble
// - FFh with Fh means always on
// - duty applies on high-byte write
// - common duty follows channel A0
// - leaving common duty keeps outputs
// - eight-bit mode: FFh always on
// - exponential curve maps high byte
// - reset, fallback reload curve, frequency
// - duty clears at reset, reloads on fallback
`timescale 1ns/1ps
module lcpwm_top
  import lcpwm_pkg::*;
#(
  parameter int unsigned CYC_PER_US = CLK_MHZ // Cycles per microsecond for settle delays.
)(
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire lcpwm_nv_t    nv_defaults,
  input  wire logic         fallback_enter,
  output lcpwm_drive_t      drive
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Exponential-style curve: cube plus a linear floor,
  // strictly rising; the top code is 4064.
  function automatic logic [11:0] exp_curve(input logic [7:0] hb);
    logic [31:0] cube;
    logic [31:0] sum;
    cube = 32'(hb) * 32'(hb) * 32'(hb);
    sum  = (cube >> 13) + (32'(hb) << 3);
    return sum[11:0];
  endfunction

  // Applied duty from stored bytes and mode.
  function automatic lcpwm_duty_t map_duty(input logic [7:0] hb, input logic [3:0] lo,
                                           input logic curve, input logic fullres);
    lcpwm_duty_t d;
    d = '0;
    if (curve)
    begin
      d.code = exp_curve(hb);
    end
    else if (fullres)
    begin
      d.code    = {hb, lo};
      d.full_on = (hb == 8'hff) && (lo == 4'hf);
    end
    else
    begin
      d.code    = {hb, 4'h0};
      d.full_on = (hb == 8'hff);
    end
    return d;
  endfunction

  // Clock cycles per base tick, at least one.
  function automatic logic [8:0] tick_div(input logic [3:0] sel);
    int unsigned q;
    q = CLK_HZ / (PWM_STEPS * DIM_FREQ_HZ[sel]);
    if (q == 0)
    begin
      q = 1;
    end
    return q[8:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [1:0]               gain_reg;        // Full range gain select.
  logic [3:0]               freq_reg;        // Dimming frequency select.
  logic [3:0]               settle_sel_reg;  // Settle delay select.
  logic                     stagger_reg;     // Phase stagger enable.
  logic                     curve_reg;       // Exponential curve select.
  logic                     common_reg;      // Common duty enable.
  logic                     fullres_reg;     // Full resolution select.
  logic [NUM_CH-1:0]        enable_reg;      // Channel output enables.
  logic [NUM_CH-1:0][5:0]   code_reg;        // Channel current codes.
  logic [NUM_CH-1:0][7:0]   high_reg;        // Duty high bytes.
  logic [NUM_CH-1:0][3:0]   low_reg;         // Duty low nibbles.
  lcpwm_duty_t [NUM_CH-1:0] applied_reg;     // Duty each generator runs on.
  logic [31:0]              rdata_reg;       // Read data captured in setup.
  logic                     err_reg;         // Error answer captured in setup.

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // No wait states, so pready is held high.
  wire       setup_phase = psel && !penable;
  wire       wr_access   = psel && penable && pwrite;
  wire [1:0] region      = paddr[7:6];
  wire [3:0] ch_sel      = paddr[5:2];
  wire       hit_ctrl    = (paddr == ADDR_CTRL);
  wire       hit_enable  = (paddr == ADDR_ENABLE);
  wire       hit_status  = (paddr == ADDR_STATUS);
  wire       hit_fall    = (paddr == ADDR_FALLBACK);
  wire       hit_chan    = (region != REGION_GLOBAL) && (paddr[1:0] == 2'h0);
  wire       mapped      = hit_ctrl || hit_enable || hit_status || hit_fall || hit_chan;
  wire       wr_ctrl     = wr_access && hit_ctrl;
  wire       wr_enable   = wr_access && hit_enable;
  wire       wr_code     = wr_access && hit_chan && (region == REGION_CODE);
  wire       wr_high     = wr_access && hit_chan && (region == REGION_HIGH);
  wire       wr_low      = wr_access && hit_chan && (region == REGION_LOW);
  // Fallback from the pin or the command word.
  wire       fall_now    = fallback_enter || (wr_access && hit_fall && pwdata[0]);
  // Leaving common duty copies A0's duty into every channel.
  wire       common_off  = wr_ctrl && common_reg && !pwdata[CTRL_COMMON];

  assign pready  = 1'b1;
  assign pslverr = err_reg;
  assign prdata  = rdata_reg;

  // ---------------------------------------------------------------------------
  // PWM base tick and period counter
  // ---------------------------------------------------------------------------
  logic [8:0]  div_cnt_reg;   // Cycles within one base tick.
  logic [11:0] period_reg;    // Base ticks within one period.
  wire  [8:0]  div_top  = tick_div(freq_reg) - 9'h001;
  wire         base_tick = (div_cnt_reg >= div_top);

  // Base tick divider; ">=" recovers when the rate rises.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_cnt_reg <= 9'h000;
    end
    else
    begin
      div_cnt_reg <= base_tick ? 9'h000 : div_cnt_reg + 9'h001;
    end
  end

  // Period counter; it wraps after 4096 ticks.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      period_reg <= 12'h000;
    end
    else if (base_tick)
    begin
      period_reg <= period_reg + 12'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // Global configuration
  // ---------------------------------------------------------------------------
  // Curve and frequency reload from storage.
  always_ff @(posedge ref_clk)
  begin
    if (srst || fall_now)
    begin
      curve_reg <= nv_defaults.curve_select;
      freq_reg  <= nv_defaults.dimming_freq_select;
    end
    else if (wr_ctrl)
    begin
      curve_reg <= pwdata[CTRL_CURVE];
      freq_reg  <= pwdata[CTRL_FREQ_LSB +: 4];
    end
  end

  // Remaining configuration fields and channel enables.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      gain_reg       <= GAIN_RESET;
      settle_sel_reg <= SETTLE_RESET;
      stagger_reg    <= 1'b0;
      common_reg     <= 1'b0;
      fullres_reg    <= FULLRES_RESET;
      enable_reg     <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        gain_reg       <= pwdata[CTRL_GAIN_LSB +: 2];
        settle_sel_reg <= pwdata[CTRL_SETTLE_LSB +: 4];
        stagger_reg    <= pwdata[CTRL_STAGGER];
        common_reg     <= pwdata[CTRL_COMMON];
        fullres_reg    <= pwdata[CTRL_FULLRES];
      end
      if (wr_enable)
      begin
        enable_reg <= pwdata[NUM_CH-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Per-channel registers, generators and settle timers
  // ---------------------------------------------------------------------------
  logic [NUM_CH-1:0] pwm_on;      // Raw generator output per channel.
  logic [NUM_CH-1:0] chan_on;     // Enabled and in the on part of the period.
  logic [NUM_CH-1:0] settled;     // Settle timer has run out.

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      localparam logic [3:0]  CH_IDX = 4'(ch);
      localparam logic [11:0] OFFSET = 12'(ch / 2) * PHASE_STEP;
      wire         sel_me   = (ch_sel == CH_IDX);
      lcpwm_duty_t eff;
      logic [11:0] local_cnt;
      logic        on_q_reg;
      logic [SETTLE_W-1:0] settle_cnt_reg;

      // Code and duty registers.
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          code_reg[ch] <= CODE_RESET;
          high_reg[ch] <= HIGH_RESET;
          low_reg[ch]  <= LOW_RESET;
        end
        else if (fall_now)
        begin
          high_reg[ch] <= nv_defaults.duty_high_byte[ch];
          low_reg[ch]  <= nv_defaults.duty_low_nibble[ch];
        end
        else
        begin
          if (wr_code && sel_me)
          begin
            code_reg[ch] <= pwdata[5:0];
          end
          if (wr_high && sel_me)
          begin
            high_reg[ch] <= pwdata[7:0];
          end
          if (wr_low && sel_me)
          begin
            low_reg[ch] <= pwdata[3:0];
          end
        end
      end

      // Applied duty moves only on a high-byte write, fallback or common exit.
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          applied_reg[ch] <= '0;
        end
        else if (fall_now)
        begin
          applied_reg[ch] <= map_duty(nv_defaults.duty_high_byte[ch],
                                      nv_defaults.duty_low_nibble[ch],
                                      nv_defaults.curve_select, fullres_reg);
        end
        else if (wr_high && sel_me)
        begin
          applied_reg[ch] <= map_duty(pwdata[7:0], low_reg[ch],
                                      curve_reg, fullres_reg);
        end
        else if (common_off)
        begin
          applied_reg[ch] <= applied_reg[0];
        end
      end

      // Common duty feeds A0's duty to all.
      assign eff = common_reg ? applied_reg[0] : applied_reg[ch];

      // Each pair lags the last by an eighth period.
      assign local_cnt   = stagger_reg ? (period_reg - OFFSET) : period_reg;
      // Ticks are short enough for 1 us pulses above 200 Hz; at 200 Hz a tick is 305 cycles.
      assign pwm_on[ch]  = eff.full_on || (local_cnt < eff.code);
      assign chan_on[ch] = enable_reg[ch] && pwm_on[ch];

      // Settle timer: loads at turn-on, then counts down.
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          on_q_reg       <= 1'b0;
          settle_cnt_reg <= '0;
        end
        else
        begin
          on_q_reg <= chan_on[ch];
          if (chan_on[ch] && !on_q_reg)
          begin
            settle_cnt_reg <= SETTLE_W'(SETTLE_US[settle_sel_reg] * CYC_PER_US);
          end
          else if (settle_cnt_reg != '0)
          begin
            settle_cnt_reg <= settle_cnt_reg - 1'b1;
          end
        end
      end

      // Sampling waits for the timer on a still-on channel;
      // a delay above the on time leaves only full duty.
      assign settled[ch] = on_q_reg && (settle_cnt_reg == '0);
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Outputs toward the current sources
  // ---------------------------------------------------------------------------
  logic [9:0] gain_mult;  // Decoded multiplier.

  // Gain code to full range multiplier.
  always_comb
  begin
    unique case (gain_reg)
      2'h3:    gain_mult = 10'h200;
      2'h2:    gain_mult = 10'h100;
      2'h1:    gain_mult = 10'h080;
      2'h0:    gain_mult = 10'h040;
    endcase
  end

  // Drive bundle, combinational from the registers.
  always_comb
  begin
    drive.ref_gain_select        = gain_reg;
    drive.gain_multiplier        = gain_mult;
    drive.channel_current_code   = code_reg;
    drive.current_output_channel = chan_on;
    drive.sample_ok              = chan_on & settled;
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [31:0] rd_mux;  // Word selected by the address.

  // Read multiplexer; unmapped addresses read zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_mux[CTRL_GAIN_LSB +: 2]   = gain_reg;
      rd_mux[CTRL_FREQ_LSB +: 4]   = freq_reg;
      rd_mux[CTRL_SETTLE_LSB +: 4] = settle_sel_reg;
      rd_mux[CTRL_STAGGER]         = stagger_reg;
      rd_mux[CTRL_CURVE]           = curve_reg;
      rd_mux[CTRL_COMMON]          = common_reg;
      rd_mux[CTRL_FULLRES]         = fullres_reg;
    end
    else if (hit_enable)
    begin
      rd_mux[NUM_CH-1:0] = enable_reg;
    end
    else if (hit_status)
    begin
      rd_mux = {settled & chan_on, chan_on};
    end
    else if (hit_chan)
    begin
      unique case (region)
        REGION_CODE: rd_mux[5:0] = code_reg[ch_sel];
        REGION_HIGH: rd_mux[7:0] = high_reg[ch_sel];
        REGION_LOW:  rd_mux[3:0] = low_reg[ch_sel];
        default:     rd_mux      = 32'h0000_0000;
      endcase
    end
  end

  // Read data and error captured in setup.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end
    else if (setup_phase)
    begin
      rdata_reg <= rd_mux;
      err_reg   <= !mapped;
    end
  end

endmodule

// ==== dv/lcpwm_led_model.sv ====
// LED string model counting lit cycles per output.
`timescale 1ns/1ps
module lcpwm_led_model
  import lcpwm_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 clr,
  input  wire lcpwm_drive_t         drive,
  output logic [NUM_CH-1:0][13:0]   on_cnt
);
  // ---------------------------------------------------------------------------
  // Light meter
  // ---------------------------------------------------------------------------
  // Each string integrates its on time over whole periods.
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NUM_CH; i++)
      on_cnt[i] <= clr ? 14'h0 : on_cnt[i] + {13'h0, drive.current_output_channel[i]};
  end
endmodule

// ==== dv/lcpwm_top_sva.sv ====
// Port-level checker for the dimming block, attached by bind.
`timescale 1ns/1ps
module lcpwm_top_sva
  import lcpwm_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          srst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire lcpwm_nv_t     nv_defaults,
  input wire logic          fallback_enter,
  input wire lcpwm_drive_t  drive
);
  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Aligned words only; the global region holds four words.
  wire addr_ok = (paddr[1:0] == 2'h0) && ((paddr[7:6] != 2'h0) || (paddr[5:4] == 2'h0));

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  gain_map_a: assert property (drive.gain_multiplier == (10'd64 << drive.ref_gain_select))
    else $error("gain multiplier wrong");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("access not answered");
  reset_off_a: assert property ($fell(srst) |-> drive.current_output_channel == 16'h0)
    else $error("lit after reset");
  enable_gate_a: assert property (psel && penable && pwrite && paddr == ADDR_ENABLE |=>
    (drive.current_output_channel & ~$past(pwdata[15:0])) == 16'h0)
    else $error("disabled channel still lit");
  settle_hold_a: assert property ($rose(drive.current_output_channel[0]) |->
    !drive.sample_ok[0] [*8])
    else $error("early sampling");
  bad_addr_a: assert property (psel && penable |-> pslverr == !addr_ok)
    else $error("wrong error response");
  bad_read_a: assert property (psel && penable && !pwrite && !addr_ok |-> prdata == 32'h0)
    else $error("refused read returned data");
  status_read_a: assert property (psel && penable && !pwrite && paddr == ADDR_STATUS |->
    prdata == {$past(drive.sample_ok), $past(drive.current_output_channel)})
    else $error("wrong status word");

  cover property ($rose(drive.sample_ok[0]));
  cover property (psel && penable && pslverr);
  cover property (fallback_enter);
endmodule

bind lcpwm_top lcpwm_top_sva u_sva (.ref_clk(ref_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .nv_defaults(nv_defaults),
  .fallback_enter(fallback_enter), .drive(drive));

// ==== dv/lcpwm_top_tb.sv ====
// Self-checking testbench for the dimming block over its APB port.
`timescale 1ns/1ps
module lcpwm_top_tb
  import lcpwm_pkg::*;
;
  localparam int PER = 8192;   // Cycles per period at code 15 (divisor 2).
  logic ref_clk = 1'b0;
  logic srst = 1'b1, clr = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fallback_enter = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er;
  logic [15:0] en;
  lcpwm_nv_t nv_defaults = '0;
  lcpwm_drive_t drive;
  logic [NUM_CH-1:0][13:0] on_cnt;
  logic [7:0] hi_v [16];
  logic [3:0] lo_v [16];
  logic [5:0] cd_v [16];
  int fail_count = 0, checked = 0, n;
  always #2 ref_clk = ~ref_clk;

  lcpwm_top #(.CYC_PER_US(1)) dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nv_defaults(nv_defaults),
    .fallback_enter(fallback_enter), .drive(drive));
  lcpwm_led_model led (.ref_clk(ref_clk), .clr(clr), .drive(drive), .on_cnt(on_cnt));

  // ---------------------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Bus master and expectations
  // ---------------------------------------------------------------------------
  // An edge passes first, so calls never drive psel twice at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (k = 0; k < 64 && pready !== 1'b1; k++)
      @(posedge ref_clk);
    if (k >= 64)
    begin
      fail_count++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("slverr", {31'h0, ee}, {31'h0, er});
  endtask
  function automatic logic [7:0] adr(input logic [1:0] r, input int i);
    return {r, i[3:0], 2'b00};
  endfunction
  // Config word with frequency code 15 kept so every period is PER cycles.
  function automatic logic [31:0] cw(input logic [1:0] g, input logic [3:0] s,
                                     input logic [3:0] f);
    return {18'h0, f, s, 4'hf, g};
  endfunction
  // Lit cycles per period.
  function automatic int exp_on(input logic [7:0] h, input logic [3:0] l, input logic fr,
                                input logic cv);
    int x;
    x = h;
    if (cv)
      return 2 * (((x * x * x) >> 13) + 8 * x);
    if (h == 8'hff && (l == 4'hf || !fr))
      return PER;
    return fr ? 32 * x + 2 * l : 32 * x;
  endfunction
  task automatic rewrite;
    for (int i = 0; i < 16; i++)
      apb(1'b1, adr(REGION_HIGH, i), {24'h0, hi_v[i]});
  endtask
  task automatic window(input logic fr, input logic cv, input logic cm);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (PER) @(posedge ref_clk);
    @(negedge ref_clk);
    for (int i = 0; i < 16; i++)
      chk("on_count", en[i] ? exp_on(hi_v[cm ? 0 : i], lo_v[cm ? 0 : i], fr, cv) : 0,
          {18'h0, on_cnt[i]});
  endtask
  // Cycles from a rise of a to the next rise of b.
  task automatic skew(input int a, input int b);
    logic pa = 1'b1, pb = 1'b1, done = 1'b0;
    n = -1;
    for (int k = 0; k < 3 * PER && !done; k++)
    begin
      @(negedge ref_clk);
      if (drive.current_output_channel[a] && !pa)
        n = 0;
      else if (n >= 0)
        n++;
      done = (n >= 0) && drive.current_output_channel[b] && !pb;
      pa = drive.current_output_channel[a];
      pb = drive.current_output_channel[b];
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'ha49e));
    nv_defaults.dimming_freq_select = 4'hf;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rdchk("ctrl", ADDR_CTRL, cw(2'h3, 4'h0, 4'b1000), 1'b0);
    rdchk("enable", ADDR_ENABLE, 32'h0, 1'b0);
    rdchk("duty_high", adr(REGION_HIGH, 5), 32'h0, 1'b0);
    rdchk("unmapped", 8'h10, 32'h0, 1'b1);
    for (int g = 0; g < 4; g++)
    begin
      apb(1'b1, ADDR_CTRL, cw(g[1:0], 4'h0, 4'b1000));
      @(posedge ref_clk);
      chk("gain", 32'd64 << g, {22'h0, drive.gain_multiplier});
    end
    en = 16'hfffb;
    apb(1'b1, ADDR_ENABLE, {16'h0, en});
    for (int i = 0; i < 16; i++)
    begin
      hi_v[i] = (i == 1) ? 8'hff : 8'($urandom);
      lo_v[i] = (i == 1) ? 4'hf : 4'($urandom);
      cd_v[i] = 6'($urandom);
      apb(1'b1, adr(REGION_CODE, i), {26'h0, cd_v[i]});
      apb(1'b1, adr(REGION_LOW, i), {28'h0, lo_v[i]});
      apb(1'b1, adr(REGION_HIGH, i), {24'h0, hi_v[i]});
    end
    apb(1'b1, adr(REGION_LOW, 3), {28'h0, ~lo_v[3]});
    @(posedge ref_clk);
    for (int i = 0; i < 16; i++)
      chk("current_code", {26'h0, cd_v[i]}, {26'h0, drive.channel_current_code[i]});
    window(1'b1, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL, cw(2'h3, 4'h0, 4'b0000));
    rewrite();
    window(1'b0, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL, cw(2'h3, 4'h0, 4'b1010));
    rewrite();
    window(1'b1, 1'b1, 1'b0);
    apb(1'b1, ADDR_CTRL, cw(2'h3, 4'h0, 4'b1100));
    window(1'b1, 1'b1, 1'b1);
    apb(1'b1, ADDR_CTRL, cw(2'h3, 4'h0, 4'b1000));
    window(1'b1, 1'b1, 1'b1);
    apb(1'b1, ADDR_ENABLE, 32'hffff);
    apb(1'b1, adr(REGION_LOW, 0), 32'h0);
    apb(1'b1, adr(REGION_HIGH, 0), 32'h80);
    apb(1'b1, ADDR_CTRL, cw(2'h3, 4'h0, 4'b1100));
    skew(0, 15);
    chk("skew_aligned", 32'd0, n);
    apb(1'b1, ADDR_CTRL, cw(2'h3, 4'h0, 4'b1101));
    skew(0, 2);
    chk("skew_next", 32'd1024, n);
    skew(0, 14);
    chk("skew_last", 32'd7168, n);
    apb(1'b1, ADDR_CTRL, cw(2'h3, 4'h0, 4'b1000));
    apb(1'b1, adr(REGION_LOW, 0), 32'hf);
    apb(1'b1, adr(REGION_HIGH, 0), 32'hff);
    // Settle times stay below the period.
    for (int s = 0; s < 16; s++)
    begin
      apb(1'b1, ADDR_ENABLE, 32'h0);
      apb(1'b1, ADDR_CTRL, cw(2'h3, s[3:0], 4'b1000));
      apb(1'b1, ADDR_ENABLE, 32'h1);
      for (n = 0; n < 5000 && drive.sample_ok[0] !== 1'b1; n++)
        @(negedge ref_clk);
      chk("settle", 32'd1, {31'h0, n >= SETTLE_US[s] && n <= SETTLE_US[s] + 3});
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    nv_defaults.curve_select <= 1'b1;
    nv_defaults.duty_high_byte <= {$urandom, $urandom, $urandom, $urandom};
    nv_defaults.duty_low_nibble <= {$urandom, $urandom};
    @(posedge ref_clk);
    fallback_enter <= 1'b1;
    @(posedge ref_clk);
    fallback_enter <= 1'b0;
    rdchk("ctrl_fb", ADDR_CTRL, cw(2'h3, 4'hf, 4'b1010), 1'b0);
    rdchk("high_fb", adr(REGION_HIGH, 4), {24'h0, nv_defaults.duty_high_byte[4]}, 1'b0);
    rdchk("low_fb", adr(REGION_LOW, 4), {28'h0, nv_defaults.duty_low_nibble[4]}, 1'b0);
    rdchk("enable_fb", ADDR_ENABLE, 32'h1, 1'b0);
    apb(1'b1, 8'h14, 32'h1);
    chk("unmapped_wr", 32'd1, {31'h0, er});
    tally_and_finish();
  end
endmodule
